// ### common/itw_pkg.sv
// Constants for the register-port target with communication watchdog.
// Assumes a 40 MHz system clock; all bus pins are sampled, never clocked.
package itw_pkg;
    // Target address base; the two strap bits fill the low bits
    localparam logic [6:0] ADDR_BASE = 7'h50;
    localparam logic [7:0] GEN_CALL = 8'h00;
    // Register pointer map
    localparam logic [7:0] REG_LIVE = 8'h00;
    localparam logic [7:0] REG_FAULT = 8'h01;
    localparam logic [7:0] REG_CTRL = 8'h02;
    localparam logic [7:0] REG_WDSET = 8'h03;
    localparam logic [7:0] REG_ROLE = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h05;
    localparam logic [7:0] REG_WO = 8'h06;
    localparam logic [7:0] MEM_BASE = 8'h10;
    // Field positions and values
    localparam int CTRL_WD_EN_BIT = 0;
    localparam int FAULT_COMM_BIT = 0;
    localparam logic [3:0] ROLE_OPEN = 4'hF;
    localparam logic [3:0] ROLE_RST = 4'h0;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // Watchdog timeouts, one per select code
    localparam int CLK_MHZ = 40;
    localparam int WD_TO0_US = 1000;
    localparam int WD_TO1_US = 2000;
    localparam int WD_TO2_US = 4000;
    localparam int WD_TO3_US = 8000;
    localparam int WD_TO0_CYC = WD_TO0_US * CLK_MHZ;
    localparam int WD_TO1_CYC = WD_TO1_US * CLK_MHZ;
    localparam int WD_TO2_CYC = WD_TO2_US * CLK_MHZ;
    localparam int WD_TO3_CYC = WD_TO3_US * CLK_MHZ;
    localparam int WDC_W = 20;
endpackage

// ### hw/itw_sync.sv
// Two-flop synchroniser for a group of unrelated levels.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/1ps
module itw_sync
    #(parameter int W = 1)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } itw_sync_t;

    itw_sync_t s_r;
    itw_sync_t s_nxt;

    always_comb
    begin
        s_nxt.s1 = d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q = s_r.s2;
endmodule

// ### hw/itw_watchdog.sv
// Communication watchdog: counts while enabled and the alert is pending.
// Assumes access is a one-cycle pulse per addressed bus transfer.
`timescale 1ns/1ps
module itw_watchdog
    import itw_pkg::*;
    #(parameter int TO0_CYC = WD_TO0_CYC,
      parameter int TO1_CYC = WD_TO1_CYC,
      parameter int TO2_CYC = WD_TO2_CYC,
      parameter int TO3_CYC = WD_TO3_CYC)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic alert_act,
    input wire logic access,
    input wire logic [1:0] sel,
    output logic expire
);
    typedef struct packed {
        logic [WDC_W-1:0] cnt;
        logic fired;
        logic expire;
    } itw_wd_t;

    itw_wd_t s_r;
    itw_wd_t s_nxt;
    logic [WDC_W-1:0] limit;

    always_comb
    begin
        case (sel) // see R20, R23
            2'h0: limit = WDC_W'(TO0_CYC - 1);
            2'h1: limit = WDC_W'(TO1_CYC - 1);
            2'h2: limit = WDC_W'(TO2_CYC - 1);
            default: limit = WDC_W'(TO3_CYC - 1);
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        // One expiry per silent stretch; re-armed by access, alert drop or disable
        if (!enable || !alert_act || access) // see R17, R18, R19
        begin
            s_nxt.cnt = '0;
            s_nxt.fired = 1'b0;
        end
        else if (!s_r.fired)
        begin
            if (s_r.cnt == limit) // see R20
            begin
                s_nxt.expire = 1'b1;
                s_nxt.fired = 1'b1;
                s_nxt.cnt = '0;
            end
            else
                s_nxt.cnt = s_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign expire = s_r.expire;
endmodule

// ### hw/itw_target.sv
// Bus target register port with block transfers, access types, watchdog.
// Assumes SCL/SDA, the strap, enable and VBUS level arrive asynchronously;
// alert_req, cmd_done and hard_reset come from logic on clk_sys.
// Contract
// R1: Word write: two bytes, pointer advances between
// R2: Every byte shifted most significant bit first
// R3: Block write up to 255 contiguous registers
// R4: Controller loads transmit buffer by block write
// R5: Store byte per eight clocks, ack ninth
// R6: Byte read: pointer, repeated start, read, NACK
// R7: Read data driven right after address ack
// R8: Non-adjacent reads use separate stopped transactions
// R9: Word read: controller acks first, NACKs second
// R10: Block read returns 1 to 255 bytes
// R11: Controller empties receive buffer by block read
// R12: One byte per eight clocks, pointer increments
// R13: Read-only registers return live value
// R14: Write-only registers always read zero
// R15: Write-one-to-clear latched bits; zero keeps
// R16: Plain, dual and extended register update sources
// R17: Watchdog runs only when enable bit set
// R18: Watchdog counts while alert output asserted
// R19: Any access clears watchdog count
// R20: Timeout chosen by two-bit select field
// R21: Expiry opens role field, discharges, flags error
// R22: Discharge removed on first low crossing only
// R23: Four timeout durations are parameters
// R24: Respond only to strapped address 0x50-0x53
// R25: Never hold SCL low
// R26: Never acknowledge the general call address
// R27: Alert is active-low open-drain output
`timescale 1ns/1ps
module itw_target
    import itw_pkg::*;
    #(parameter int TO0_CYC = WD_TO0_CYC,
      parameter int TO1_CYC = WD_TO1_CYC,
      parameter int TO2_CYC = WD_TO2_CYC,
      parameter int TO3_CYC = WD_TO3_CYC)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic alert_n_out,
    output logic alert_n_oe,
    input wire logic alert_req,
    input wire logic [1:0] addr_sel,
    input wire logic dev_enable,
    input wire logic [7:0] live_status,
    input wire logic hard_reset,
    input wire logic cmd_done,
    input wire logic vbus_low,
    output logic vbus_discharge,
    output logic [3:0] role_control,
    output logic [7:0] cmd_value,
    output logic [7:0] wo_data,
    output logic wo_strobe,
    output logic [7:0] fault_status,
    output logic watchdog_enable_bit
);
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK}
        itw_state_t;

    typedef struct packed {
        itw_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic [1:0] phase;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic sda_oe;
        logic scl_d;
        logic sda_d;
        logic en_d;
        logic vlow_d;
        logic [6:0] my_addr;
        logic [7:0] fault;
        logic [7:0] ctrl;
        logic [1:0] wd_sel;
        logic [3:0] role;
        logic [7:0] cmd;
        logic [7:0] wo_data;
        logic wo_stb;
        logic discharge;
        logic fault_pend;
        logic access;
    } itw_regs_t;

    itw_regs_t s_r;
    itw_regs_t s_nxt;
    logic [7:0] mem [0:255];
    logic [7:0] rd_byte;
    logic [5:0] sync_q;
    logic scl_s, sda_s, vlow_s, en_s;
    logic [1:0] addr_sel_s;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic wd_expire;
    logic mem_we;
    logic wr_now;
    logic ld_tx;

    itw_sync #(.W(6)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .d({scl, sda_in, vbus_low, dev_enable, addr_sel}),
        .q(sync_q)
    );
    assign {scl_s, sda_s, vlow_s, en_s, addr_sel_s} = sync_q;

    itw_watchdog #(
        .TO0_CYC(TO0_CYC),
        .TO1_CYC(TO1_CYC),
        .TO2_CYC(TO2_CYC),
        .TO3_CYC(TO3_CYC)
    ) u_wd (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(s_r.ctrl[CTRL_WD_EN_BIT]), // see R17
        .alert_act(alert_req), // see R18
        .access(s_r.access), // see R19
        .sel(s_r.wd_sel), // see R20
        .expire(wd_expire)
    );

    assign scl_rise = scl_s & ~s_r.scl_d;
    assign scl_fall = ~scl_s & s_r.scl_d;
    assign start_c = scl_s & s_r.scl_d & s_r.sda_d & ~sda_s;
    assign stop_c = scl_s & s_r.scl_d & ~s_r.sda_d & sda_s;

    // Read mux works on the pointer as it stands when a byte is loaded
    always_comb
    begin
        if (s_r.ptr == REG_LIVE)
            rd_byte = live_status; // see R13
        else if (s_r.ptr == REG_FAULT)
            rd_byte = s_r.fault;
        else if (s_r.ptr == REG_CTRL)
            rd_byte = s_r.ctrl;
        else if (s_r.ptr == REG_WDSET)
            rd_byte = {6'h00, s_r.wd_sel};
        else if (s_r.ptr == REG_ROLE)
            rd_byte = {4'h0, s_r.role};
        else if (s_r.ptr == REG_CMD)
            rd_byte = s_r.cmd;
        else if (s_r.ptr == REG_WO)
            rd_byte = 8'h00; // see R14
        else if (s_r.ptr >= MEM_BASE)
            rd_byte = mem[s_r.ptr];
        else
            rd_byte = 8'h00;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wo_stb = 1'b0;
        s_nxt.access = 1'b0;
        s_nxt.scl_d = scl_s;
        s_nxt.sda_d = sda_s;
        s_nxt.en_d = en_s;
        s_nxt.vlow_d = vlow_s;
        mem_we = 1'b0;
        wr_now = 1'b0;
        ld_tx = 1'b0;
        // Address is caught once per enable, not tracked afterwards
        if (en_s && !s_r.en_d)
            s_nxt.my_addr = ADDR_BASE | {5'h00, addr_sel_s}; // see R24
        if (cmd_done || hard_reset)
            s_nxt.cmd = REG_RST; // see R16
        // Edge only: a later rise of VBUS does not re-arm it
        if (s_r.discharge && vlow_s && !s_r.vlow_d)
            s_nxt.discharge = 1'b0; // see R22
        if (!en_s || stop_c)
        begin
            s_nxt.st = ST_IDLE;
            s_nxt.sda_oe = 1'b0;
        end
        else if (start_c)
        begin
            s_nxt.st = ST_RX;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.phase = 2'h0;
            s_nxt.sda_oe = 1'b0;
        end
        else
        begin
            case (s_r.st)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        s_nxt.sh = {s_r.sh[6:0], sda_s}; // see R2
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end
                    else if (scl_fall && s_r.bit_cnt == BYTE_BITS) // see R5
                    begin
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.st = ST_ACK;
                        s_nxt.sda_oe = 1'b1;
                        if (s_r.phase == 2'h0)
                        begin
                            if (s_r.sh[7:1] == s_r.my_addr &&
                                s_r.sh != GEN_CALL) // see R24, R26
                            begin
                                s_nxt.rw = s_r.sh[0];
                                s_nxt.phase = 2'h1;
                                s_nxt.access = 1'b1; // see R19
                            end
                            else
                            begin
                                s_nxt.st = ST_IDLE;
                                s_nxt.sda_oe = 1'b0;
                            end
                        end
                        else if (s_r.phase == 2'h1)
                        begin
                            s_nxt.ptr = s_r.sh;
                            s_nxt.phase = 2'h2;
                        end
                        else
                        begin
                            wr_now = 1'b1;
                            // Pointer wraps, so any block length fits
                            s_nxt.ptr = s_r.ptr + 8'h01; // see R1, R3, R5
                            if (s_r.ptr == REG_FAULT)
                                s_nxt.fault = s_r.fault & ~s_r.sh; // see R15
                            else if (s_r.ptr == REG_CTRL)
                                s_nxt.ctrl = s_r.sh; // see R16
                            else if (s_r.ptr == REG_WDSET)
                                s_nxt.wd_sel = s_r.sh[1:0];
                            else if (s_r.ptr == REG_ROLE)
                                s_nxt.role = s_r.sh[3:0];
                            else if (s_r.ptr == REG_CMD)
                                s_nxt.cmd = s_r.sh;
                            else if (s_r.ptr == REG_WO)
                            begin
                                s_nxt.wo_data = s_r.sh;
                                s_nxt.wo_stb = 1'b1;
                            end
                            else if (s_r.ptr >= MEM_BASE)
                                mem_we = 1'b1;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (s_r.rw)
                        begin
                            ld_tx = 1'b1; // see R6, R7
                            s_nxt.sh = rd_byte;
                            s_nxt.sda_oe = ~rd_byte[7];
                            s_nxt.st = ST_TX;
                        end
                        else
                        begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (s_r.bit_cnt == BYTE_BITS - 4'h1)
                        begin
                            s_nxt.bit_cnt = 4'h0;
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st = ST_RACK;
                            s_nxt.ptr = s_r.ptr + 8'h01; // see R9, R10, R12
                        end
                        else
                        begin
                            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                            s_nxt.sh = {s_r.sh[6:0], 1'b0}; // see R2
                            s_nxt.sda_oe = ~s_r.sh[6];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                        s_nxt.nack = sda_s; // see R12
                    else if (scl_fall)
                    begin
                        if (s_r.nack)
                            s_nxt.st = ST_IDLE; // see R6, R9
                        else
                        begin
                            ld_tx = 1'b1;
                            s_nxt.sh = rd_byte;
                            s_nxt.sda_oe = ~rd_byte[7];
                            s_nxt.st = ST_TX;
                        end
                    end
                end
                default:
                    s_nxt.sda_oe = 1'b0;
            endcase
        end
        // Watchdog events come last so they win over a same-cycle write
        if (wd_expire)
        begin
            s_nxt.role = ROLE_OPEN; // see R16, R21
            s_nxt.discharge = 1'b1;
            s_nxt.fault_pend = 1'b1;
        end
        else if (s_r.fault_pend)
        begin
            s_nxt.fault[FAULT_COMM_BIT] = 1'b1; // see R21
            s_nxt.fault_pend = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (mem_we)
            mem[s_r.ptr] <= s_r.sh;
    end

    // No SCL output exists: the target never stretches the clock
    assign sda_out = 1'b0; // see R25
    assign sda_oe = s_r.sda_oe;
    assign alert_n_out = 1'b0;
    assign alert_n_oe = alert_req; // see R27
    assign vbus_discharge = s_r.discharge;
    assign role_control = s_r.role;
    assign cmd_value = s_r.cmd;
    assign wo_data = s_r.wo_data;
    assign wo_strobe = s_r.wo_stb;
    assign fault_status = s_r.fault;
    assign watchdog_enable_bit = s_r.ctrl[CTRL_WD_EN_BIT];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_wr_ptr_step: assert property (wr_now |=> // see R1
        s_r.ptr == $past(s_r.ptr) + 8'h01)
        else $error("pointer did not advance after write");
    a_rd_ptr_step: assert property (s_r.st == ST_TX && // see R12
        s_nxt.st == ST_RACK |=> s_r.ptr == $past(s_r.ptr) + 8'h01)
        else $error("pointer did not advance after read byte");
    a_gen_call_nak: assert property (s_r.st == ST_RX && // see R26
        s_r.phase == 2'h0 && scl_fall && s_r.bit_cnt == BYTE_BITS &&
        s_r.sh == GEN_CALL && en_s && !start_c && !stop_c |=> !s_r.sda_oe)
        else $error("general call acknowledged");
    a_addr_ack_hold: assert property (s_r.access |-> // see R24
        s_r.sda_oe && s_r.st == ST_ACK)
        else $error("matched address not acknowledged");
    a_ro_live_val: assert property (ld_tx && // see R13
        s_r.ptr == REG_LIVE |=> s_r.sh == $past(live_status))
        else $error("live register not sampled on load");
    a_wo_read_zero: assert property (ld_tx && // see R14
        s_r.ptr == REG_WO |=> s_r.sh == 8'h00)
        else $error("write-only register read nonzero");
    a_w1c_keep_bit: assert property (s_r.fault[FAULT_COMM_BIT] && // see R15
        !(wr_now && s_r.ptr == REG_FAULT && s_r.sh[FAULT_COMM_BIT])
        |=> s_r.fault[FAULT_COMM_BIT])
        else $error("latched fault bit lost");
    a_expire_seq: assert property (wd_expire |=> // see R21
        s_r.role == ROLE_OPEN && s_r.discharge ##1
        s_r.fault[FAULT_COMM_BIT])
        else $error("expiry sequence wrong");
    a_dis_release: assert property (s_r.discharge && vlow_s && // see R22
        !s_r.vlow_d && !wd_expire |=> !s_r.discharge)
        else $error("discharge not removed on low crossing");
    a_wd_disabled: assert property (!s_r.ctrl[CTRL_WD_EN_BIT] // see R17
        [*2] |-> !wd_expire)
        else $error("watchdog expired while disabled");
    a_sda_scl_low: assert property ($changed(s_r.sda_oe) && // see R5
        !$past(stop_c) && !$past(start_c) && $past(en_s) |-> !scl_s)
        else $error("sda drive changed with scl high");

    c_block_write: cover property (wr_now ##[1:300] wr_now);
    c_read_nack: cover property (s_r.st == ST_RACK && s_r.nack);
    c_wd_expire: cover property (wd_expire);
    c_dis_done: cover property (s_r.discharge ##1 !s_r.discharge);
endmodule

// ### testbench/itw_ctl_model.sv
// Bus controller model: makes SCL and drives SDA as an open-drain source.
// Assumes the bench resolves sda_line from all pull-down enables.
`timescale 1ns/1ps
module itw_ctl_model
(
    input wire logic clk_sys,
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    // SCL stands high between frames
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Serves as repeated start too, since SDA is raised while SCL is low
    task automatic start();
        sda_drv <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_drv <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic stop();
        sda_drv <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        sda_drv <= 1'b1;
        hold(4);
    endtask

    // Sample late in the high phase, well clear of the target's update
    task automatic bit_io(input logic b, output logic s);
        sda_drv <= b;
        hold(2);
        scl <= 1'b1;
        hold(4);
        s = sda_line;
        scl <= 1'b0;
        hold(2);
    endtask

    task automatic tx(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, ack_n);
    endtask

    task automatic rx(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule

// ### testbench/i2c_target_regport_watchdog_tb_top.sv
// Testbench for the register-port target: bus transfers and watchdog.
// Assumes itw_ctl_model as the bus controller and short watchdog counts.
`timescale 1ns/1ps
module i2c_target_regport_watchdog_tb_top
    import itw_pkg::*;
();
    localparam int TO[4] = '{400, 800, 1200, 1600};
    localparam logic [1:0] STRAP = 2'b10;
    localparam logic [7:0] AW = {ADDR_BASE | {5'h00, STRAP}, 1'b0};
    logic clk_sys = 1'b0;
    logic reset_n, scl, sda_drv, sda_line, sda_out, sda_oe;
    logic alert_n_out, alert_n_oe, alert_req, dev_enable;
    logic [1:0] addr_sel;
    logic [7:0] live_status, cmd_value, wo_data, fault_status;
    logic hard_reset, cmd_done, vbus_low, vbus_discharge, wo_strobe;
    logic watchdog_enable_bit;
    logic [3:0] role_control;
    int failures = 0;
    int n_checks = 0;
    int n_wo_stb = 0;

    always #12.5 clk_sys = ~clk_sys;
    // Counts write-only strobes so a stuck or missing pulse shows up
    always @(posedge clk_sys)
        if (wo_strobe)
            n_wo_stb++;
    // Pull-up on SDA; the target pulls low while its sda_oe is high
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    itw_ctl_model ctl (.clk_sys(clk_sys), .scl(scl), .sda_drv(sda_drv),
        .sda_line(sda_line));

    itw_target #(.TO0_CYC(TO[0]), .TO1_CYC(TO[1]), .TO2_CYC(TO[2]),
        .TO3_CYC(TO[3])) dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .alert_req(alert_req), .addr_sel(addr_sel),
        .dev_enable(dev_enable), .live_status(live_status),
        .hard_reset(hard_reset), .cmd_done(cmd_done), .vbus_low(vbus_low),
        .vbus_discharge(vbus_discharge), .role_control(role_control),
        .cmd_value(cmd_value), .wo_data(wo_data), .wo_strobe(wo_strobe),
        .fault_status(fault_status),
        .watchdog_enable_bit(watchdog_enable_bit));

    task automatic summarize();
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic probe(input logic [7:0] a);
        logic n;
        ctl.start();
        ctl.tx(a, n);
        chk(n, 1'b1);
        ctl.stop();
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
        logic n;
        ctl.start();
        ctl.tx(AW, n);
        chk(n, 1'b0);
        ctl.tx(p, n);
        chk(n, 1'b0);
        foreach (d[i])
        begin
            ctl.tx(d[i], n);
            chk(n, 1'b0);
        end
        ctl.stop();
    endtask

    // Acks every byte but the last, which is refused before the stop
    task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
        logic n;
        logic [7:0] v;
        ctl.start();
        ctl.tx(AW, n);
        chk(n, 1'b0);
        ctl.tx(p, n);
        chk(n, 1'b0);
        ctl.start();
        ctl.tx(AW | 8'h01, n);
        chk(n, 1'b0);
        foreach (e[i])
        begin
            ctl.rx(i == e.size() - 1, v);
            chk(v, e[i]);
        end
        ctl.stop();
    endtask

    initial
    begin
        wait_clk(40000);
        failures++;
        summarize();
    end

    initial
    begin
        {reset_n, alert_req, dev_enable, hard_reset, cmd_done} = 5'h00;
        vbus_low = 1'b0;
        addr_sel = STRAP;
        live_status = 8'h00;
        wait_clk(2);
        reset_n <= 1'b1;
        wait_clk(2);
        dev_enable <= 1'b1;
        wait_clk(12);
        probe(GEN_CALL);
        probe({ADDR_BASE | 7'h01, 1'b0});
        wr(MEM_BASE, '{8'hA5, 8'h3C, 8'hF0});
        rd(MEM_BASE, '{8'hA5, 8'h3C, 8'hF0});
        rd(MEM_BASE, '{8'hA5, 8'h3C});
        rd(MEM_BASE + 8'h02, '{8'hF0});
        live_status <= 8'h5A;
        rd(REG_LIVE, '{8'h5A});
        live_status <= 8'hC3;
        rd(REG_LIVE, '{8'hC3});
        wr(REG_WO, '{8'h96});
        chk(wo_data, 8'h96);
        chk(8'(n_wo_stb), 8'h01);
        rd(REG_WO, '{8'h00});
        wr(REG_CMD, '{8'h33});
        chk(cmd_value, 8'h33);
        cmd_done <= 1'b1;
        wait_clk(1);
        cmd_done <= 1'b0;
        wait_clk(2);
        chk(cmd_value, REG_RST);
        wr(REG_CMD, '{8'h44});
        hard_reset <= 1'b1;
        wait_clk(1);
        hard_reset <= 1'b0;
        wait_clk(2);
        chk(cmd_value, REG_RST);
        wr(REG_ROLE, '{8'h07});
        rd(REG_ROLE, '{8'h07});
        alert_req <= 1'b1;
        wait_clk(2);
        chk(alert_n_oe, 1'b1);
        chk(alert_n_out, 1'b0);
        wait_clk(TO[3] + 100);
        chk(role_control, 4'h7);
        alert_req <= 1'b0;
        wr(REG_CTRL, '{8'h01});
        chk(watchdog_enable_bit, 1'b1);
        alert_req <= 1'b1;
        wait_clk(300);
        wr(MEM_BASE, '{8'h11});
        wait_clk(200);
        chk(role_control, 4'h7);
        alert_req <= 1'b0;
        wait_clk(2);
        chk(alert_n_oe, 1'b0);
        // A dropped alert must restart the count from zero
        alert_req <= 1'b1;
        wait_clk(300);
        alert_req <= 1'b0;
        wait_clk(2);
        alert_req <= 1'b1;
        wait_clk(300);
        chk(role_control, 4'h7);
        alert_req <= 1'b0;
        for (int s = 0; s < 4; s++)
        begin
            wr(REG_WDSET, '{{6'h00, 2'(s)}});
            alert_req <= 1'b1;
            wait_clk(TO[s] - 20);
            chk(role_control, 4'h7);
            wait_clk(40);
            chk(role_control, ROLE_OPEN);
            chk(vbus_discharge, 1'b1);
            chk(fault_status, 8'h01);
            alert_req <= 1'b0;
            vbus_low <= 1'b1;
            wait_clk(8);
            chk(vbus_discharge, 1'b0);
            vbus_low <= 1'b0;
            wait_clk(8);
            chk(vbus_discharge, 1'b0);
            wr(REG_FAULT, '{8'h00});
            rd(REG_FAULT, '{8'h01});
            wr(REG_FAULT, '{8'h01});
            rd(REG_FAULT, '{8'h00});
            wr(REG_ROLE, '{8'h07});
        end
        summarize();
    end
endmodule
